// File: rtl/ahb_reg_port.sv
`timescale 1ns/1ps
`default_nettype none

module ahb_reg_port
    import wdt_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    // Decoded register access
    output reg_access_t access
);

    bus_state_t s;
    bus_state_t next_s;
    logic addrPhase;

    // Only word transfers exist; hsize is accepted but not checked
    assign addrPhase = hsel & htrans[1] & hready;

    // Writes land in the data phase; zero wait states, always OKAY
    always_comb begin
        next_s = s;
        next_s.ready = 1'b1;
        next_s.resp = 1'b0;
        next_s.wrPend = addrPhase & hwrite;
        next_s.wrIndex = wordIndex(haddr);
    end

    // Single state register
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            s <= '{wrPend: 1'b0, wrIndex: 16'hFFFF, ready: 1'b1, resp: 1'b0};
        end else begin
            s <= next_s;
        end
    end

    // Reads decode in the address phase so the data is registered in time
    assign access.rd = addrPhase & ~hwrite;
    assign access.rdIndex = wordIndex(haddr);
    assign access.wr = s.wrPend;
    assign access.wrIndex = s.wrIndex;
    assign access.wdata = hwdata[7:0];
    assign hreadyout = s.ready;
    assign hresp = s.resp;

    logic unusedSize;
    assign unusedSize = ^hsize;

endmodule : ahb_reg_port

`default_nettype wire

// File: rtl/ls_edge_detect.sv
`timescale 1ns/1ps
`default_nettype none

module ls_edge_detect
    import wdt_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // Asynchronous pin
    input wire logic pinIn,
    // Edge pulses
    output logic rise,
    output logic fall
);

    edge_state_t s;
    edge_state_t next_s;

    // Level moves only once the second and third stages agree
    always_comb begin
        next_s = s;
        next_s.sync = {s.sync[1:0], pinIn};
        next_s.rise = 1'b0;
        next_s.fall = 1'b0;
        if (s.sync[1] == s.sync[2] && s.sync[2] != s.level) begin
            next_s.level = s.sync[2];
            next_s.rise = s.sync[2];
            next_s.fall = ~s.sync[2];
        end
    end

    // Single state register
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign rise = s.rise;
    assign fall = s.fall;

endmodule : ls_edge_detect

`default_nettype wire

// File: rtl/two_stage_watchdog_timer.sv
// How it works
// - Reading the clear-key register returns the key-phase pointer in bit 0.
// - Pointer resets to 0 on reset or overflow; toggles on every key write outside the overflow hold.
// - Counter clears only after 5A at pointer 0 then A5 at pointer 1.
// - Out-of-phase keys are not accepted but still toggle the pointer.
// - First overflow without a clear raises the non-maskable interrupt.
// - A second overflow without a clear asserts watchdog reset.
// - After first overflow, counter and pointer held clear for half a slow cycle.
// - Period select: 00 125ms, 01 500ms, 10 2s (reset), 11 8s.
// - Counting starts after reset release and first slow-clock edges.
// - Free-running; software has no way to stop it.
// - STOP mode halts the counter.
// - Counter runs in HALT; the interrupt releases HALT.
`timescale 1ns/1ps
`default_nettype none

`include "wdt_consts.svh"

module two_stage_watchdog_timer
    import wdt_pkg::*;
#(
    parameter int unsigned OVF_TICKS0 = `WDT_TICKS(`WDT_TWOV0_MS),
    parameter int unsigned OVF_TICKS1 = `WDT_TICKS(`WDT_TWOV1_MS),
    parameter int unsigned OVF_TICKS2 = `WDT_TICKS(`WDT_TWOV2_MS),
    parameter int unsigned OVF_TICKS3 = `WDT_TICKS(`WDT_TWOV3_MS)
)
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // Low-speed clock pin
    input wire logic lowSpeedClock,
    // Power modes from the same clock domain
    input wire logic stopMode,
    input wire logic haltMode,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Watchdog outputs
    output logic overflowInterrupt,
    output logic watchdogReset,
    output logic haltRelease,
    output logic irq
);

    // ----------------------------------------
    // Operating notes
    // ----------------------------------------
    // Register map as word indexes; the byte address is four times the index
    //   Key 0xF00E: any byte written toggles the pointer; a read gives it in bit 0
    //   Period 0xF00F: bits 1:0 pick the overflow period, 2 after reset
    //   Status 0xF010: bit 0 first overflow, bit 1 refused key write
    //   Clear 0xF011: ones written drop the matching status bits
    //   Enable 0xF012: status bits that may drive irq
    // Unmapped or unaligned reads give zero; writes there do nothing
    // Only the low byte of the write data matters
    // No wait states and never an error response, so the bus cannot stall
    //
    // Bus timing
    //   Writes land at the end of their data phase
    //   Reads are decoded in the address phase, data registered for the next
    //   A read right behind a write sees the state before that write
    //   Software that polls the pointer leaves one idle cycle first
    //
    // Slow clock handling
    //   The slow clock arrives as a plain pin, not as a clock
    //   Three flops and an agreement test turn its edges into one-cycle ticks
    //   Ticks lag the pin by about four system cycles
    //   The system clock must run well above twice the slow clock
    //   A glitch shorter than one system cycle never reaches the counter
    //
    // Counter
    //   Counts rising slow ticks only; no register can stop it
    //   STOP freezes it in place; HALT leaves it running
    //   Overflow is the tick that arrives while the count sits at its limit
    //   Limits come from the period parameters, one below the tick count
    //   A period change applies at once to the running count
    //   Shortening the period with a large count overflows at the next tick
    //
    // Clear sequence
    //   First key at pointer 0 arms, second key at pointer 1 clears
    //   Any other key write disarms and flags a refused key in status
    //   A clear also forgets the first overflow, restarting both stages
    //   Every accepted key write toggles the pointer, whatever the byte
    //
    // Overflow stages
    //   First overflow: one-cycle non-maskable pulse and status bit 0
    //   Counter and pointer then held clear until the next slow falling edge
    //   Key writes inside that hold are dropped and leave the pointer alone
    //   Software in the handler should recheck the pointer after each write
    //   Second overflow without a clear raises the reset output
    //   The reset output stays high until rst_b takes the block down
    //
    // Halt wake
    //   A first overflow seen while haltMode is high also pulses haltRelease
    //   Both pulses share one cycle so the controller sees them together
    //
    // Interrupt line
    //   irq is a level, high while an enabled status bit is set
    //   A status set and its clear in one cycle keep the bit set
    //   The non-maskable pulse ignores the enable register on purpose
    //
    // Reset
    //   rst_b is synchronous and active low
    //   Period returns to 2, pointer, status and enable to 0
    //   Bus answers ready even while in reset
    //
    // Limitations
    //   The hold is measured in slow edges, so a stopped slow clock stretches it
    //   No lock on the period register; software may change it at any time
    //   The count is not readable; only the pointer is visible

    // ----------------------------------------
    // Submodules
    // ----------------------------------------
    reg_access_t access;
    logic lsRise;
    logic lsFall;

    ahb_reg_port busPort (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .access(access)
    );

    // The slow clock is sampled as a pin, so its edges become system ticks
    ls_edge_detect lsEdge (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .pinIn(lowSpeedClock),
        .rise(lsRise),
        .fall(lsFall)
    );

    // ----------------------------------------
    // Period limit
    // ----------------------------------------
    wdt_state_t s;
    wdt_state_t next_s;
    count_t limit;

    // Last count before overflow for the selected period
    always_comb begin
        unique case (s.periodSel)
            2'h0: limit = count_t'(OVF_TICKS0 - 1);
            2'h1: limit = count_t'(OVF_TICKS1 - 1);
            2'h2: limit = count_t'(OVF_TICKS2 - 1);
            2'h3: limit = count_t'(OVF_TICKS3 - 1);
        endcase
    end

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic tick;
    logic keyWrite;
    logic keyClear;
    logic badKey;
    logic [1:0] events;

    // No enable gates the count; only STOP freezes it
    assign tick = lsRise & ~stopMode;

    always_comb begin
        next_s = s;
        next_s.nmiPulse = 1'b0;
        next_s.haltWake = 1'b0;
        keyWrite = access.wr && access.wrIndex == `WDT_IDX_KEY;
        keyClear = 1'b0;
        badKey = 1'b0;
        events = 2'h0;

        // Key writes are dropped while the overflow hold lasts
        if (keyWrite && !s.holdInit) begin
            next_s.pointer = ~s.pointer;
            if (!s.pointer && access.wdata == `WDT_KEY_FIRST) begin
                next_s.armed = 1'b1;
            end else if (s.pointer && s.armed && access.wdata == `WDT_KEY_SECOND) begin
                next_s.armed = 1'b0;
                keyClear = 1'b1;
            end else begin
                next_s.armed = 1'b0;
                badKey = 1'b1;
            end
        end

        // Other register writes
        if (access.wr) begin
            unique case (access.wrIndex)
                `WDT_IDX_PERIOD: begin
                    next_s.periodSel = access.wdata[`WDT_SEL_MSB:`WDT_SEL_LSB];
                end
                `WDT_IDX_CLEAR: begin
                    next_s.status = s.status & ~access.wdata[1:0];
                end
                `WDT_IDX_ENABLE: begin
                    next_s.enable = access.wdata[1:0];
                end
                default: begin
                end
            endcase
        end

        // Counter: hold, clear, count or overflow
        if (s.holdInit) begin
            next_s.count = '0;
            next_s.pointer = 1'b0;
            next_s.armed = 1'b0;
            if (lsFall) begin
                next_s.holdInit = 1'b0;
            end
        end else if (keyClear) begin
            next_s.count = '0;
            next_s.firstOvf = 1'b0;
        end else if (tick) begin
            if (s.count >= limit) begin
                next_s.count = '0;
                next_s.pointer = 1'b0;
                next_s.armed = 1'b0;
                if (s.firstOvf) begin
                    next_s.wdtReset = 1'b1;
                end else begin
                    next_s.firstOvf = 1'b1;
                    next_s.holdInit = 1'b1;
                    next_s.nmiPulse = 1'b1;
                    next_s.haltWake = haltMode;
                    events[`WDT_EV_OVF] = 1'b1;
                end
            end else begin
                next_s.count = s.count + count_t'(1);
            end
        end

        // Sticky events; a set in the clearing cycle wins
        events[`WDT_EV_BADKEY] = badKey;
        next_s.status = next_s.status | events;
        next_s.irq = |(next_s.status & next_s.enable);

        // Read data, registered for the data phase
        if (access.rd) begin
            unique case (access.rdIndex)
                `WDT_IDX_KEY: next_s.rdata = {31'h0000_0000, s.pointer};
                `WDT_IDX_PERIOD: next_s.rdata = {30'h0000_0000, s.periodSel};
                `WDT_IDX_STATUS: next_s.rdata = {30'h0000_0000, s.status};
                `WDT_IDX_ENABLE: next_s.rdata = {30'h0000_0000, s.enable};
                default: next_s.rdata = 32'h0000_0000;
            endcase
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            s <= '0;
            s.pointer <= `WDT_KEY_RESET;
            s.periodSel <= `WDT_PERIOD_RESET;
            s.status <= `WDT_EV_RESET;
        end else begin
            s <= next_s;
        end
    end

    // ----------------------------------------
    // Outputs, each straight from the state
    // ----------------------------------------
    assign hrdata = s.rdata;
    assign overflowInterrupt = s.nmiPulse;
    // Stays high until the system reset it causes clears it
    assign watchdogReset = s.wdtReset;
    assign haltRelease = s.haltWake;
    assign irq = s.irq;

endmodule : two_stage_watchdog_timer

`default_nettype wire

// File: rtl/wdt_consts.svh
`ifndef WDT_CONSTS_SVH
`define WDT_CONSTS_SVH

// ----------------------------------------
// Register indexes (byte address = 4 * index)
// ----------------------------------------
`define WDT_IDX_KEY 16'hF00E
`define WDT_IDX_PERIOD 16'hF00F
`define WDT_IDX_STATUS 16'hF010
`define WDT_IDX_CLEAR 16'hF011
`define WDT_IDX_ENABLE 16'hF012

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define WDT_PTR_BIT 0
`define WDT_SEL_LSB 0
`define WDT_SEL_MSB 1
`define WDT_EV_OVF 0
`define WDT_EV_BADKEY 1
`define WDT_PERIOD_RESET 2'h2
`define WDT_KEY_RESET 1'h0
`define WDT_EV_RESET 2'h0

// ----------------------------------------
// Clear keys
// ----------------------------------------
`define WDT_KEY_FIRST 8'h5A
`define WDT_KEY_SECOND 8'hA5

// ----------------------------------------
// Overflow periods in ms and low-speed ticks
// ----------------------------------------
`define WDT_LS_HZ 32768
`define WDT_TWOV0_MS 125
`define WDT_TWOV1_MS 500
`define WDT_TWOV2_MS 2000
`define WDT_TWOV3_MS 8000
`define WDT_TICKS(ms) (((ms) * `WDT_LS_HZ) / 1000)

`endif

// File: rtl/wdt_pkg.sv
package wdt_pkg;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef logic [17:0] count_t;

    // Register access decoded from the bus
    typedef struct packed {
        logic rd;
        logic [15:0] rdIndex;
        logic wr;
        logic [15:0] wrIndex;
        logic [7:0] wdata;
    } reg_access_t;

    // Bus port state
    typedef struct packed {
        logic wrPend;
        logic [15:0] wrIndex;
        logic ready;
        logic resp;
    } bus_state_t;

    // Pin synchroniser state
    typedef struct packed {
        logic [2:0] sync;
        logic level;
        logic rise;
        logic fall;
    } edge_state_t;

    // Watchdog core state
    typedef struct packed {
        count_t count;
        logic pointer;
        logic armed;
        logic [1:0] periodSel;
        logic holdInit;
        logic firstOvf;
        logic wdtReset;
        logic nmiPulse;
        logic haltWake;
        logic [1:0] status;
        logic [1:0] enable;
        logic irq;
        logic [31:0] rdata;
    } wdt_state_t;

    // Word index of a byte address, or all ones when outside the map or not word aligned
    function automatic logic [15:0] wordIndex(input logic [31:0] addr);
        if (addr[31:18] == 14'h0000 && addr[1:0] == 2'h0) begin
            return addr[17:2];
        end
        return 16'hFFFF;
    endfunction : wordIndex

endpackage : wdt_pkg

// File: tb/two_stage_watchdog_timer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

`include "wdt_consts.svh"

module two_stage_watchdog_timer_tb_top;
    // Shortened counts: one slow tick is 40 system cycles
    localparam int TICKS [4] = '{8, 16, 32, 64};
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic lowSpeedClock = 1'b0;
    logic stopMode = 1'b0;
    logic haltMode = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] hrdata;
    logic hreadyout, hresp, overflowInterrupt, watchdogReset, haltRelease, irq;
    int errTotal = 0;
    int cmpCount = 0;
    int ovfSeen = 0;
    int haltSeen = 0;

    // Clocks; slow pin offset so it never moves on a system edge
    always #5 clk_sys = ~clk_sys;
    initial #3 forever #200 lowSpeedClock = ~lowSpeedClock;

    two_stage_watchdog_timer #(
        .OVF_TICKS0(TICKS[0]),
        .OVF_TICKS1(TICKS[1]),
        .OVF_TICKS2(TICKS[2]),
        .OVF_TICKS3(TICKS[3])
    ) DUT (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .lowSpeedClock(lowSpeedClock),
        .stopMode(stopMode),
        .haltMode(haltMode),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(3'h2),
        .hwdata(hwdata),
        .hready(hreadyout),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .hrdata(hrdata),
        .overflowInterrupt(overflowInterrupt),
        .watchdogReset(watchdogReset),
        .haltRelease(haltRelease),
        .irq(irq)
    );

    // Pulse tallies taken mid-cycle, clear of the edge
    always @(negedge clk_sys) begin
        if (overflowInterrupt === 1'b1) ovfSeen++;
        if (haltRelease === 1'b1) haltSeen++;
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
        cmpCount++;
        if (s !== e) begin
            errTotal++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask : check

    // One single word transfer; waits on hready, no fixed latency assumed
    task automatic busOp(input logic [15:0] i, input logic w, input logic [7:0] d,
                         output logic [31:0] q);
        @(posedge clk_sys);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {14'h0000, i, 2'h0};
        hwrite <= w;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= {24'h00_0000, d};
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask : busOp

    task automatic wr(input logic [15:0] i, input logic [7:0] d);
        logic [31:0] q;
        busOp(i, 1'b1, d, q);
    endtask : wr

    task automatic rdChk(input string n, input logic [15:0] i, input logic [31:0] e);
        logic [31:0] q;
        busOp(i, 1'b0, 8'h00, q);
        check(n, q, e);
        check("resp", 32'(hresp), 0);
    endtask : rdChk

    task automatic clearSeq;
        wr(`WDT_IDX_KEY, `WDT_KEY_FIRST);
        wr(`WDT_IDX_KEY, `WDT_KEY_SECOND);
    endtask : clearSeq

    task automatic waitOvf(output int n);
        int s;
        s = ovfSeen;
        n = 0;
        while (ovfSeen == s && n < 3000) begin
            @(posedge clk_sys);
            n++;
        end
    endtask : waitOvf

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic testPointer;
        rdChk("key", `WDT_IDX_KEY, 0);
        rdChk("period", `WDT_IDX_PERIOD, 2);
        rdChk("unmapped", 16'h0100, 0);
        wr(`WDT_IDX_KEY, 8'h33);
        rdChk("ptr", `WDT_IDX_KEY, 1);
        wr(`WDT_IDX_KEY, `WDT_KEY_FIRST);
        wr(`WDT_IDX_KEY, `WDT_KEY_SECOND);
        rdChk("ptr bad", `WDT_IDX_KEY, 1);
        wr(`WDT_IDX_KEY, 8'h00);
        rdChk("status", `WDT_IDX_STATUS, 2);
        wr(`WDT_IDX_ENABLE, 8'h02);
        repeat (2) @(posedge clk_sys);
        check("irq", 32'(irq), 1);
        wr(`WDT_IDX_ENABLE, 8'h00);
        repeat (2) @(posedge clk_sys);
        check("masked", 32'(irq), 0);
        wr(`WDT_IDX_CLEAR, 8'h02);
        rdChk("cleared", `WDT_IDX_STATUS, 0);
        $display("testPointer done");
    endtask : testPointer

    // Each select measured from a clear; a key write inside the hold is dropped
    task automatic testPeriods;
        int n;
        int t;
        for (int s = 0; s < 4; s++) begin
            wr(`WDT_IDX_PERIOD, 8'(s));
            rdChk("sel", `WDT_IDX_PERIOD, 32'(s));
            clearSeq();
            waitOvf(n);
            wr(`WDT_IDX_KEY, `WDT_KEY_FIRST);
            t = TICKS[s] * 40;
            check("span", 32'(n >= t - 40 && n <= t + 20), 1);
            rdChk("held", `WDT_IDX_KEY, 0);
            repeat (40) @(posedge clk_sys);
        end
        $display("testPeriods done");
    endtask : testPeriods

    task automatic testStage;
        int n;
        wr(`WDT_IDX_PERIOD, 8'h00);
        clearSeq();
        waitOvf(n);
        check("first", 32'(watchdogReset), 0);
        rdChk("ovf status", `WDT_IDX_STATUS, 1);
        n = 0;
        while (watchdogReset !== 1'b1 && n < 1000) begin
            @(posedge clk_sys);
            n++;
        end
        @(posedge clk_sys);
        check("second", 32'(watchdogReset), 1);
        rst_b <= 1'b0;
        repeat (16) @(posedge clk_sys);
        rst_b <= 1'b1;
        rdChk("sel rst", `WDT_IDX_PERIOD, 2);
        check("wd rst", 32'(watchdogReset), 0);
        $display("testStage done");
    endtask : testStage

    task automatic testStopHalt;
        int n;
        int o;
        wr(`WDT_IDX_PERIOD, 8'h00);
        o = ovfSeen;
        repeat (4) begin
            clearSeq();
            repeat (200) @(posedge clk_sys);
        end
        clearSeq();
        stopMode <= 1'b1;
        repeat (1000) @(posedge clk_sys);
        check("kept", 32'(ovfSeen - o), 0);
        stopMode <= 1'b0;
        waitOvf(n);
        check("resume", 32'(n < 400), 1);
        repeat (40) @(posedge clk_sys);
        clearSeq();
        o = haltSeen;
        haltMode <= 1'b1;
        waitOvf(n);
        repeat (2) @(posedge clk_sys);
        check("wake", 32'(haltSeen - o), 1);
        haltMode <= 1'b0;
        $display("testStopHalt done");
    endtask : testStopHalt

    task automatic completeRun;
        $display("Compared %0d, mismatches %0d", cmpCount, errTotal);
        if (errTotal == 0 && cmpCount > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : completeRun

    // Main sequence
    initial begin
        repeat (16) @(posedge clk_sys);
        rst_b <= 1'b1;
        testPointer();
        testPeriods();
        testStage();
        testStopHalt();
        completeRun();
    end

    // About 8k cycles expected; cut off well beyond
    initial begin
        #400000;
        errTotal++;
        completeRun();
    end
endmodule : two_stage_watchdog_timer_tb_top

bind two_stage_watchdog_timer wdt_assertions chk (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .lowSpeedClock(lowSpeedClock),
    .stopMode(stopMode),
    .haltMode(haltMode),
    .hrdata(hrdata),
    .overflowInterrupt(overflowInterrupt),
    .watchdogReset(watchdogReset),
    .haltRelease(haltRelease),
    .irq(irq)
);

`default_nettype wire

// File: tb/wdt_assertions.sv
`timescale 1ns/1ps
`default_nettype none

module wdt_assertions (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // Watched pins
    input wire logic lowSpeedClock,
    input wire logic stopMode,
    input wire logic haltMode,
    input wire logic [31:0] hrdata,
    input wire logic overflowInterrupt,
    input wire logic watchdogReset,
    input wire logic haltRelease,
    input wire logic irq
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    // Cycles since the raw slow pin rose; saturates so it never wraps
    logic lscPrev;
    logic [7:0] sinceRise;
    always_ff @(posedge clk_sys) begin
        lscPrev <= lowSpeedClock;
        if (lowSpeedClock && !lscPrev) begin
            sinceRise <= 8'h00;
        end else if (sinceRise != 8'hFF) begin
            sinceRise <= sinceRise + 8'h01;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_ovf_one_cycle: assert property (overflowInterrupt |=> !overflowInterrupt)
        else $error("overflow pulse too long");
    a_ovf_after_tick: assert property (overflowInterrupt |-> sinceRise <= 8'h0A)
        else $error("overflow without slow tick");
    a_ovf_spaced: assert property (overflowInterrupt |=> !overflowInterrupt [*8])
        else $error("overflows too close");
    a_halt_wake: assert property (haltRelease |-> overflowInterrupt && $past(haltMode))
        else $error("halt release without cause");
    a_wdreset_holds: assert property (watchdogReset |=> watchdogReset)
        else $error("watchdog reset dropped");
    a_stop_frozen: assert property (stopMode [*8] |-> !overflowInterrupt)
        else $error("overflow in stop");
    a_reset_clean: assert property ($rose(rst_b) |-> !watchdogReset && !irq && hrdata == 0)
        else $error("outputs not clear after reset");
    a_rdata_narrow: assert property (hrdata[31:2] == 30'h0000_0000)
        else $error("read data upper bits set");

    // Main scenarios reached
    c_ovf: cover property (overflowInterrupt);
    c_wdreset: cover property ($rose(watchdogReset));
    c_halt: cover property (haltRelease);
endmodule : wdt_assertions

`default_nettype wire
